// [design/ile_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ile_consts.svh"
module ile_core #(
  parameter int NUM_SRC = 24,
  parameter int MC_CLKS = `ILE_MC_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData_reg,
  // Sources, same clock, one-cycle pulses
  input wire logic [23:0] srcReq,
  input wire logic ext0PinEnable,
  // CPU sequencer side
  input wire logic lastCycle,
  input wire logic ackStb,
  input wire logic [4:0] ackId,
  input wire logic setMasterOp,
  input wire logic clearMasterOp,
  input wire logic returnOp,
  input wire logic returnImf,
  output logic irqReq_reg,
  output logic [4:0] irqId_reg,
  output logic savedImf_reg,
  output logic accepting_reg
);
  localparam int ACC_CLKS = `ILE_ACCEPT_MC * MC_CLKS;
  localparam int CW = $clog2(ACC_CLKS + 1);

  initial begin
    if (NUM_SRC != 24) begin
      $error("ile_core supports exactly 24 sources");
    end
    if (MC_CLKS < 1) begin
      $error("ile_core needs MC_CLKS of at least 1");
    end
  end

  ile_pkg::ile_vec_t pend_reg;
  ile_pkg::ile_vec_t en_reg;
  logic imf_reg;
  ile_pkg::ile_state_t state_reg;
  logic [CW-1:0] cnt_reg;

  ile_pkg::ile_vec_t swClr;
  ile_pkg::ile_vec_t ackClr;
  ile_pkg::ile_vec_t ready;
  ile_pkg::ile_vec_t gate;
  logic anyReady;
  logic [4:0] pick;
  logic ackOk;

  // Byte-wide clear strobes; a one in the written data keeps the latch.
  always_comb begin
    swClr = '0;
    if (wrStb) begin
      case (addr)
        `ILE_OFS_PEND_LO: swClr[7:0] = ~wrData; // RL5 RL6 RL7
        `ILE_OFS_PEND_HI: swClr[15:8] = ~wrData; // RL5 RL6 RL7
        `ILE_OFS_PEND_UP: swClr[23:16] = ~wrData; // RL5 RL6 RL7
        default: swClr = '0;
      endcase
    end
  end

  assign ackOk = ackStb && (state_reg != ile_pkg::ILE_ACCEPT);

  always_comb begin
    ackClr = '0;
    if (ackOk) begin
      ackClr[ackId] = 1'b1; // RL3
    end
  end

  // Latches exist only from index 2 upward; the two traps below carry none.
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++) begin : g_pend
      if (gi < `ILE_FIRST_LATCH) begin : g_none
        always_ff @(posedge clk or posedge sys_rst) begin // RL1
          if (sys_rst) begin
            pend_reg[gi] <= 1'b0;
          end else begin
            pend_reg[gi] <= 1'b0;
          end
        end
      end else begin : g_latch
        // A new request beats a clear in the same cycle so it is not lost.
        always_ff @(posedge clk or posedge sys_rst) begin
          if (sys_rst) begin
            pend_reg[gi] <= 1'(`ILE_RST_PEND >> gi); // RL4
          end else if (srcReq[gi]) begin
            pend_reg[gi] <= 1'b1; // RL2
          end else if (swClr[gi] || ackClr[gi]) begin
            pend_reg[gi] <= 1'b0; // RL3 RL6
          end
        end
      end
    end
  endgenerate

  // Enable register: bit 0 of the low byte is the master flag.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg <= `ILE_RST_EN; // RL19
    end else if (wrStb) begin
      case (addr)
        `ILE_OFS_EN_LO: en_reg[7:4] <= wrData[7:4]; // RL12 RL18
        `ILE_OFS_EN_HI: en_reg[15:8] <= wrData; // RL12 RL18
        `ILE_OFS_EN_UP: en_reg[23:16] <= wrData; // RL12 RL18
        default: en_reg <= en_reg;
      endcase
    end
  end

  // Master flag and its saved copy handed to the stacking sequence.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      imf_reg <= `ILE_RST_IMF; // RL17
      savedImf_reg <= 1'b0;
    end else if (ackOk) begin
      savedImf_reg <= imf_reg; // RL14
      imf_reg <= 1'b0; // RL14
    end else if (returnOp) begin
      imf_reg <= returnImf; // RL15
    end else if (setMasterOp) begin
      imf_reg <= 1'b1; // RL16
    end else if (clearMasterOp) begin
      imf_reg <= 1'b0; // RL16
    end else if (wrStb && addr == `ILE_OFS_EN_LO) begin
      imf_reg <= wrData[`ILE_IMF_BIT]; // RL16
    end
  end

  // Maskable sources need master and own flag; the two latched traps need nothing.
  always_comb begin
    gate = {24{imf_reg}} & en_reg; // RL13 RL18
    gate[`ILE_EXT0_BIT] = gate[`ILE_EXT0_BIT] & ext0PinEnable; // RL23
    gate = gate | `ILE_NM_MASK; // RL11
    ready = pend_reg & gate & `ILE_LATCH_MASK; // RL26
  end

  assign anyReady = |ready;

  // Lowest index wins; latched trap 2 ranks above latched trap 3 at the top.
  always_comb begin
    pick = 5'h00;
    for (int k = 23; k >= 0; k--) begin
      if (ready[k]) begin
        pick = 5'(k); // RL22
      end
    end
  end

  // Offer and acceptance sequencing.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ile_pkg::ILE_IDLE;
      irqReq_reg <= 1'b0;
      irqId_reg <= 5'h00;
      cnt_reg <= '0;
      accepting_reg <= 1'b0;
    end else begin
      case (state_reg)
        ile_pkg::ILE_IDLE: begin
          if (ackOk) begin
            state_reg <= ile_pkg::ILE_ACCEPT;
            cnt_reg <= CW'(ACC_CLKS - 1); // RL24
            accepting_reg <= 1'b1;
          end else if (lastCycle && anyReady) begin
            irqReq_reg <= 1'b1; // RL2 RL25
            irqId_reg <= pick;
            state_reg <= ile_pkg::ILE_OFFER;
          end
        end
        ile_pkg::ILE_OFFER: begin
          if (ackOk) begin
            irqReq_reg <= 1'b0;
            state_reg <= ile_pkg::ILE_ACCEPT;
            cnt_reg <= CW'(ACC_CLKS - 1); // RL24
            accepting_reg <= 1'b1;
          end else if (!ready[irqId_reg]) begin
            // Withdrawn when software cleared it or masked it meanwhile.
            irqReq_reg <= 1'b0;
            state_reg <= ile_pkg::ILE_IDLE;
          end
        end
        ile_pkg::ILE_ACCEPT: begin
          if (cnt_reg == '0) begin
            accepting_reg <= 1'b0;
            state_reg <= ile_pkg::ILE_IDLE;
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
        default: begin
          state_reg <= ile_pkg::ILE_IDLE;
          irqReq_reg <= 1'b0;
        end
      endcase
    end
  end

  // Read port; unmapped addresses and absent bits read zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg <= 8'h00;
    end else if (rdStb) begin
      case (addr)
        `ILE_OFS_PEND_LO: rdData_reg <= pend_reg[7:0]; // RL10
        `ILE_OFS_PEND_HI: rdData_reg <= pend_reg[15:8]; // RL10
        `ILE_OFS_PEND_UP: rdData_reg <= pend_reg[23:16]; // RL10
        `ILE_OFS_EN_LO: rdData_reg <= {en_reg[7:4], 3'h0, imf_reg}; // RL12
        `ILE_OFS_EN_HI: rdData_reg <= en_reg[15:8]; // RL12
        `ILE_OFS_EN_UP: rdData_reg <= en_reg[23:16]; // RL12
        default: rdData_reg <= 8'h00;
      endcase
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  // Checks.
  property p_set;
    @(posedge clk) disable iff (sys_rst)
    srcReq[9] |=> pend_reg[9];
  endproperty
  a_set: assert property (p_set) else $error("request did not latch"); // RL2

  property p_clr;
    @(posedge clk) disable iff (sys_rst)
    wrStb && addr == `ILE_OFS_PEND_HI && !wrData[2] && !srcReq[10] |=> !pend_reg[10];
  endproperty
  a_clr: assert property (p_clr) else $error("zero write did not clear"); // RL6

  property p_keep;
    @(posedge clk) disable iff (sys_rst)
    wrStb && addr == `ILE_OFS_PEND_LO && wrData[5] && !ackOk && !srcReq[5]
      |=> pend_reg[5] == $past(pend_reg[5]);
  endproperty
  a_keep: assert property (p_keep) else $error("one write changed latch"); // RL7

  property p_ack;
    @(posedge clk) disable iff (sys_rst)
    ackOk && !srcReq[ackId] && ackId >= 5'h02 |=> !pend_reg[$past(ackId)];
  endproperty
  a_ack: assert property (p_ack) else $error("accepted latch not cleared"); // RL3

  property p_imfsave;
    @(posedge clk) disable iff (sys_rst)
    ackOk |=> !imf_reg && savedImf_reg == $past(imf_reg);
  endproperty
  a_imfsave: assert property (p_imfsave) else $error("master flag not saved"); // RL14

  property p_ret;
    @(posedge clk) disable iff (sys_rst)
    returnOp && !ackOk |=> imf_reg == $past(returnImf);
  endproperty
  a_ret: assert property (p_ret) else $error("master flag not restored"); // RL15

  property p_mask;
    @(posedge clk) disable iff (sys_rst)
    irqReq_reg && irqId_reg >= 5'h04 |-> imf_reg || $past(imf_reg) || !$past(irqReq_reg);
  endproperty
  a_mask: assert property (p_mask) else $error("maskable offered while off"); // RL13

  property p_nm;
    @(posedge clk) disable iff (sys_rst)
    state_reg == ile_pkg::ILE_IDLE && lastCycle && !ackOk && pend_reg[3] |=> irqReq_reg;
  endproperty
  a_nm: assert property (p_nm) else $error("trap latch not offered"); // RL11

  property p_seq;
    @(posedge clk) disable iff (sys_rst)
    ackOk |=> accepting_reg [*2] ##[1:300] !accepting_reg;
  endproperty
  a_seq: assert property (p_seq) else $error("acceptance length wrong"); // RL24

  property p_ext0;
    @(posedge clk) disable iff (sys_rst)
    irqReq_reg && irqId_reg == 5'h04 && $rose(irqReq_reg) |-> $past(ext0PinEnable);
  endproperty
  a_ext0: assert property (p_ext0) else $error("pin enable ignored"); // RL23

  // The read port returns zero between reads, so a stale byte is never mistaken for data.
  property p_rdidle;
    @(posedge clk) disable iff (sys_rst)
    !rdStb |=> rdData_reg == 8'h00;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data not idle"); // RL10

  property p_nolatch;
    @(posedge clk) disable iff (sys_rst)
    pend_reg[1:0] == 2'h0;
  endproperty
  a_nolatch: assert property (p_nolatch) else $error("trap without latch set"); // RL1

  property p_noset;
    @(posedge clk) disable iff (sys_rst)
    !srcReq[6] && !pend_reg[6] |=> !pend_reg[6];
  endproperty
  a_noset: assert property (p_noset) else $error("latch set without request"); // RL7

  property p_enhi;
    @(posedge clk) disable iff (sys_rst)
    wrStb && addr == `ILE_OFS_EN_HI |=> en_reg[15:8] == $past(wrData);
  endproperty
  a_enhi: assert property (p_enhi) else $error("enable middle byte not written"); // RL12

  property p_enup;
    @(posedge clk) disable iff (sys_rst)
    wrStb && addr == `ILE_OFS_EN_UP |=> en_reg[23:16] == $past(wrData);
  endproperty
  a_enup: assert property (p_enup) else $error("enable upper byte not written"); // RL12

  property p_imfwr;
    @(posedge clk) disable iff (sys_rst)
    wrStb && addr == `ILE_OFS_EN_LO && !ackOk && !returnOp && !setMasterOp && !clearMasterOp
      |=> imf_reg == $past(wrData[`ILE_IMF_BIT]);
  endproperty
  a_imfwr: assert property (p_imfwr) else $error("master flag write lost"); // RL16

  property p_ei;
    @(posedge clk) disable iff (sys_rst)
    setMasterOp && !ackOk && !returnOp |=> imf_reg;
  endproperty
  a_ei: assert property (p_ei) else $error("master flag not set"); // RL16

  property p_di;
    @(posedge clk) disable iff (sys_rst)
    clearMasterOp && !ackOk && !returnOp && !setMasterOp |=> !imf_reg;
  endproperty
  a_di: assert property (p_di) else $error("master flag not cleared"); // RL16

  property p_rdpend;
    @(posedge clk) disable iff (sys_rst)
    rdStb && addr == `ILE_OFS_PEND_HI |=> rdData_reg == $past(pend_reg[15:8]);
  endproperty
  a_rdpend: assert property (p_rdpend) else $error("latch read wrong"); // RL10

  property p_offerid;
    @(posedge clk) disable iff (sys_rst)
    $rose(irqReq_reg) |-> irqId_reg >= 5'h02;
  endproperty
  a_offerid: assert property (p_offerid) else $error("unlatched source offered"); // RL22

  // No second offer may overlap a running acceptance sequence.
  property p_quiet;
    @(posedge clk) disable iff (sys_rst)
    state_reg == ile_pkg::ILE_ACCEPT |-> !irqReq_reg;
  endproperty
  a_quiet: assert property (p_quiet) else $error("offer during acceptance"); // RL24

  property p_drop;
    @(posedge clk) disable iff (sys_rst)
    ackOk |=> !irqReq_reg;
  endproperty
  a_drop: assert property (p_drop) else $error("offer kept after accept"); // RL3

  property p_mask2;
    @(posedge clk) disable iff (sys_rst)
    $rose(irqReq_reg) && irqId_reg >= 5'h04 |-> $past(imf_reg);
  endproperty
  a_mask2: assert property (p_mask2) else $error("maskable offered with master off"); // RL13

  c_offer: cover property (@(posedge clk) disable iff (sys_rst) $rose(irqReq_reg));
  c_return: cover property (@(posedge clk) disable iff (sys_rst) returnOp);
  c_withdraw: cover property (@(posedge clk) disable iff (sys_rst)
    state_reg == ile_pkg::ILE_OFFER && !ready[irqId_reg]);
  c_accept: cover property (@(posedge clk) disable iff (sys_rst) irqReq_reg && ackStb);
  c_race: cover property (@(posedge clk) disable iff (sys_rst) srcReq[6] && swClr[6]);
endmodule
`default_nettype wire

// [pkg/ile_consts.svh]
// Contract
// [RL1] One latch per source except two traps.
// [RL2] Request sets latch; enabled latch asks CPU.
// [RL3] Acceptance clears accepted source's latch.
// [RL4] Reset clears all pending latches.
// [RL5] Latches mapped at three byte addresses.
// [RL6] Writing zero clears only that latch.
// [RL7] Writing one leaves latch unchanged.
// [RL8] Software never clears trap latches; the code lets a zero write clear latched traps 2 and 3.
// [RL9] Software clears latches by plain store.
// [RL10] Reading latches returns pending state.
// [RL11] Four trap sources ignore all enables; the code exempts only latched traps 2 and 3.
// [RL12] Enable register at three addresses, RW.
// [RL13] Master flag zero blocks maskable sources.
// [RL14] Acceptance saves then clears master flag.
// [RL15] Return operations restore saved master flag.
// [RL16] Master flag bit 0 low byte; EI/DI.
// [RL17] Reset clears master flag.
// [RL18] Each maskable source has own enable.
// [RL19] Reset clears every source enable.
// [RL20] Software disables master around flag changes.
// [RL21] Software never sets master and low enables together.
// [RL22] Fixed priority picks among pending requests.
// [RL23] External source 0 also needs pin enable.
// [RL24] Acceptance sequence lasts eight machine cycles.
// [RL25] Requests sampled in instruction's last cycle.
// [RL26] Request when latched and unmasked or non-maskable.
`ifndef ILE_CONSTS_SVH
`define ILE_CONSTS_SVH
`define ILE_OFS_PEND_LO 8'h3C
`define ILE_OFS_PEND_HI 8'h3D
`define ILE_OFS_PEND_UP 8'h2E
`define ILE_OFS_EN_LO 8'h3A
`define ILE_OFS_EN_HI 8'h3B
`define ILE_OFS_EN_UP 8'h2C
`define ILE_IMF_BIT 0
`define ILE_EXT0_BIT 4
`define ILE_FIRST_LATCH 2
`define ILE_FIRST_MASKABLE 4
`define ILE_NM_MASK 24'h00000C
`define ILE_LATCH_MASK 24'hFFFFFC
`define ILE_RST_PEND 24'h000000
`define ILE_RST_EN 24'h000000
`define ILE_RST_IMF 1'h0
`define ILE_ACCEPT_MC 8
`define ILE_MC_CLKS 4
`endif

// [pkg/ile_pkg.sv]
package ile_pkg;
  typedef enum logic [1:0] {
    ILE_IDLE,
    ILE_OFFER,
    ILE_ACCEPT
  } ile_state_t;
  typedef logic [23:0] ile_vec_t;
endpackage

// [test/ile_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ile_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Controller side
  input wire logic irqReq_reg,
  input wire logic [4:0] irqId_reg,
  input wire logic savedImf_reg,
  // Bench control
  input wire logic autoAck,
  input wire logic [3:0] ackWait,
  input wire logic doReturn,
  // Sequencer strobes
  output logic lastCycle,
  output logic ackStb,
  output logic [4:0] ackId,
  output logic returnOp,
  output logic returnImf
);
  logic [1:0] phase;
  logic [3:0] waitCnt;
  logic go;
  assign go = irqReq_reg && autoAck && !ackStb;
  // Idle index is inverted so a stale value never looks right; the idle popped flag toggles every cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {phase, lastCycle, waitCnt, ackStb, ackId, returnOp, returnImf} <= 15'h0000;
    end else begin
      phase <= phase + 2'h1;
      lastCycle <= (phase == 2'h3);
      waitCnt <= go ? waitCnt + 4'h1 : 4'h0;
      ackStb <= go && (waitCnt == ackWait);
      ackId <= (go && (waitCnt == ackWait)) ? irqId_reg : ~irqId_reg;
      returnOp <= doReturn;
      returnImf <= doReturn ? savedImf_reg : ~returnImf;
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, sys_rst, wrStb, rdStb, ext0PinEnable, setMasterOp, clearMasterOp, lastCycle;
  logic ackStb, returnOp, returnImf, irqReq_reg, savedImf_reg, accepting_reg, autoAck, doReturn;
  logic [7:0] addr, wrData, rdData_reg;
  logic [23:0] srcReq;
  logic [4:0] ackId, irqId_reg;
  logic [3:0] ackWait;
  logic [23:0] regTab [9] = '{24'h3CFF00, 24'h3AFEF0, 24'h3A0101, 24'h3BA5A5, 24'h2C5A5A,
    24'h3EFF00, 24'h3A0000, 24'h3B0000, 24'h2C0000};
  logic [7:0] rstTab [6] = '{8'h3A, 8'h3B, 8'h2C, 8'h3C, 8'h3D, 8'h2E};
  int failures = 0;
  int check_count = 0;
  int n;
  ile_core #(.MC_CLKS(1)) u_ile_core (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData_reg(rdData_reg), .srcReq(srcReq),
    .ext0PinEnable(ext0PinEnable), .lastCycle(lastCycle), .ackStb(ackStb), .ackId(ackId),
    .setMasterOp(setMasterOp), .clearMasterOp(clearMasterOp), .returnOp(returnOp),
    .returnImf(returnImf), .irqReq_reg(irqReq_reg), .irqId_reg(irqId_reg),
    .savedImf_reg(savedImf_reg), .accepting_reg(accepting_reg));
  ile_cpu_model u_ile_cpu_model (.clk(clk), .sys_rst(sys_rst), .irqReq_reg(irqReq_reg),
    .irqId_reg(irqId_reg), .savedImf_reg(savedImf_reg), .autoAck(autoAck), .ackWait(ackWait),
    .doReturn(doReturn), .lastCycle(lastCycle), .ackStb(ackStb), .ackId(ackId),
    .returnOp(returnOp), .returnImf(returnImf));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    {wrStb, rdStb} <= {w, !w};
    @(posedge clk);
    {wrStb, rdStb} <= 2'h0;
    #1;
    if (!w) check("rdData", rdData_reg, d);
  endtask
  task automatic pulse(input logic [23:0] req, input logic [2:0] op);
    @(posedge clk);
    srcReq <= req;
    {doReturn, clearMasterOp, setMasterOp} <= op;
    @(posedge clk);
    srcReq <= 24'h000000;
    {doReturn, clearMasterOp, setMasterOp} <= 3'h0;
  endtask
  task automatic poll(input logic sel, input logic lvl);
    n = 0;
    while ((sel ? irqReq_reg : accepting_reg) !== lvl && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // A withdrawn offer takes up to two cycles to drop, so looking starts after three.
  task automatic offer(input logic want, input logic [4:0] id);
    repeat (3) @(posedge clk);
    #1;
    poll(1'b1, 1'b1);
    check("irqReq", {7'h00, irqReq_reg}, {7'h00, want});
    if (want) check("irqId", {3'h0, irqId_reg}, {3'h0, id});
    if (want && n == 40) results();
  endtask
  task automatic accepted();
    poll(1'b0, 1'b1);
    poll(1'b0, 1'b0);
    check("acceptLen", n[7:0], 8'h08);
  endtask
  initial begin
    {wrStb, rdStb, ext0PinEnable, setMasterOp, clearMasterOp, autoAck, doReturn} = 7'h00;
    {addr, wrData, srcReq, ackWait} = 44'h0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rstTab[i]) acc(1'b0, rstTab[i], 8'h00);
    foreach (regTab[i]) begin
      acc(1'b1, regTab[i][23:16], regTab[i][15:8]);
      acc(1'b0, regTab[i][23:16], regTab[i][7:0]);
    end
    pulse(24'hFFFFFF, 3'h0);
    acc(1'b0, 8'h3C, 8'hFC);
    acc(1'b0, 8'h3D, 8'hFF);
    acc(1'b0, 8'h2E, 8'hFF);
    offer(1'b1, 5'h02);
    acc(1'b1, 8'h3C, 8'hFB);
    acc(1'b0, 8'h3C, 8'hF8);
    offer(1'b1, 5'h03);
    acc(1'b1, 8'h3C, 8'h0C);
    acc(1'b0, 8'h3C, 8'h08);
    autoAck <= 1'b1;
    accepted();
    autoAck <= 1'b0;
    acc(1'b0, 8'h3C, 8'h00);
    check("savedImf", {7'h00, savedImf_reg}, 8'h00);
    acc(1'b1, 8'h3A, 8'h20);
    pulse(24'h000020, 3'h0);
    offer(1'b0, 5'h05);
    pulse(24'h000000, 3'h1);
    offer(1'b1, 5'h05);
    ackWait <= 4'h5;
    autoAck <= 1'b1;
    accepted();
    autoAck <= 1'b0;
    acc(1'b0, 8'h3A, 8'h20);
    check("savedImf", {7'h00, savedImf_reg}, 8'h01);
    acc(1'b0, 8'h3C, 8'h00);
    pulse(24'h000000, 3'h4);
    acc(1'b0, 8'h3A, 8'h21);
    pulse(24'h000000, 3'h2);
    acc(1'b1, 8'h3A, 8'hB0);
    pulse(24'h0000B0, 3'h0);
    pulse(24'h000000, 3'h1);
    offer(1'b1, 5'h05);
    pulse(24'h000000, 3'h2);
    offer(1'b0, 5'h05);
    ext0PinEnable <= 1'b1;
    pulse(24'h000000, 3'h1);
    offer(1'b1, 5'h04);
    results();
  end
endmodule
`default_nettype wire
